// ### core/addru_pkg.sv
// Package: constants and types of the address unit
package addru_pkg;
  // ==========================================
  // Widths and counts
  localparam int ADDR_W = 16;
  localparam int NUM_PTR = 4;
  localparam int IDX_W = 2;
  localparam int DISP_W = 7;
  localparam logic [1:0] DUAL_PTR = 2'h3;
  // ==========================================
  // Modifier encoding: all ones is linear, zero is reverse carry,
  // any other value is modulo with modulus value+1
  localparam logic [15:0] MOD_LINEAR = 16'hFFFF;
  localparam logic [15:0] MOD_REVERSE = 16'h0000;
  localparam logic [15:0] RESET_PTR = 16'h0000;
  localparam logic [15:0] RESET_OFS = 16'h0000;
  localparam logic [15:0] RESET_MOD = 16'hFFFF;
  // ==========================================
  // Addressing mode and class types
  typedef enum logic [2:0] {
    AM_NONE, AM_POSTINC, AM_POSTDEC, AM_POSTOFS, AM_INDEXED, AM_PREDEC, AM_SHORTDISP
  } addru_mode_t;
  typedef enum logic [2:0] {
    SRC_POINTER, SRC_ACCUPPER, SRC_ABSOLUTE, SRC_IMMEDIATE, SRC_IMPLIED
  } addru_src_t;
  typedef enum logic [1:0] {
    ST_EXEC, ST_EXTRA
  } addru_state_t;
endpackage : addru_pkg

// ### core/addru_update.sv
// Pointer update arithmetic: linear, reverse carry and modulo
`timescale 1ns/1ps
module addru_update #(
  parameter int W = 16
) (
  input wire logic [W-1:0] pointer,
  input wire logic [W-1:0] step,
  input wire logic [W-1:0] modifier,
  input wire logic noModulo,
  output logic [W-1:0] result
);
  // ==========================================
  // Bit reversal helper
  function automatic logic [W-1:0] revBits(input logic [W-1:0] v);
    logic [W-1:0] r;
    r = '0;
    for (int i = 0; i < W; i++) begin
      r[i] = v[W-1-i];
    end
    return r;
  endfunction : revBits

  // ==========================================
  // Candidate results
  wire logic [W-1:0] linearSum = pointer + step; // Wraps modulo 2^W
  // Carry runs MSB to LSB by reversing, adding, reversing
  wire logic [W-1:0] reverseSum = revBits(revBits(pointer) + revBits(step));
  // Modulo window: base is pointer with the bits of modifier ORed with its right shifts by 1, 2, 4 and 8 cleared
  wire logic [W-1:0] modulus = modifier + 16'h0001;
  wire logic [W-1:0] topBit = modifier | (modifier >> 1) | (modifier >> 2)
                              | (modifier >> 4) | (modifier >> 8);
  wire logic [W-1:0] base = pointer & ~topBit;
  wire logic [W-1:0] offs = pointer - base;
  wire logic [W-1:0] rawOffs = offs + step;
  wire logic stepNeg = step[W-1];
  wire logic [W-1:0] wrapUp = rawOffs - modulus;
  wire logic [W-1:0] wrapDown = rawOffs + modulus;
  wire logic overTop = !stepNeg && (rawOffs >= modulus);
  wire logic underBase = stepNeg && (offs < (~step + 16'h0001));
  wire logic [W-1:0] modOffs = overTop ? wrapUp : (underBase ? wrapDown : rawOffs);
  wire logic [W-1:0] moduloSum = base + modOffs;
  // Mode chosen from the paired modifier; forced linear when modulo is off
  wire logic isLinear = noModulo || (modifier == addru_pkg::MOD_LINEAR);
  wire logic isReverse = !isLinear && (modifier == addru_pkg::MOD_REVERSE);
  assign result = isLinear ? linearSum : (isReverse ? reverseSum : moduloSum);
endmodule : addru_update

// ### core/address_unit.sv
// Address unit: pointer files, effective location and pointer update
//
// Function
// - Indirect address is the pointer, except offset-indexed, short-displacement and pre-decrement modes.
// - Pointer n always pairs with offset n, and with modifier n on the first access only.
// - Modifier content picks linear, reverse carry or modulo, and modulus.
// - Linear update is 16-bit wrapping, step offset, plus one, minus one, displacement.
// - Offsets work signed or unsigned with identical wrap results.
// - Reverse carry propagates from MSB toward LSB.
// - Power-of-two offset in reverse mode equals reverse, increment, reverse.
// - Modulo unit updates one pointer per cycle, all three arithmetic types.
// - Second read updates pointer 3 without its modifier, no modulo.
// - Two pointer sets may serve one instruction, one per memory access.
// - Both accesses complete within one instruction cycle; both updates too, unless both target pointer 3.
// - Multi-word instructions take one extra execution cycle.
// - Memory-oriented and flow-change instructions block parallel accesses and updates.
// - Accumulator upper word, immediate, absolute, implied usable as address.
`timescale 1ns/1ps
module address_unit #(
  parameter int W = 16
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic instValid,
  input wire logic instTwoWord,
  input wire logic instBlocksParallel,
  input wire logic firstEnable,
  input wire logic [1:0] firstIndex,
  input wire addru_pkg::addru_mode_t firstMode,
  input wire addru_pkg::addru_src_t firstSource,
  input wire logic [6:0] shortDisp,
  input wire logic [W-1:0] accUpper,
  input wire logic [W-1:0] immediateAddr,
  input wire logic secondEnable,
  input wire addru_pkg::addru_mode_t secondMode,
  input wire logic writeEnable,
  input wire logic [1:0] writeFile,
  input wire logic [1:0] writeIndex,
  input wire logic [W-1:0] writeData,
  output logic [W-1:0] firstAddr,
  output logic firstValid,
  output logic [W-1:0] secondAddr,
  output logic secondValid,
  output logic busy,
  output logic [W-1:0] pointerView
);
  // ==========================================
  // Register files, arrays declared here
  logic [W-1:0] pointerFile [addru_pkg::NUM_PTR];
  logic [W-1:0] offsetFile [addru_pkg::NUM_PTR];
  logic [W-1:0] modifierFile [addru_pkg::NUM_PTR];
  addru_pkg::addru_state_t state;
  addru_pkg::addru_state_t next_state;

  // Step for each mode
  function automatic logic [W-1:0] stepOf(input addru_pkg::addru_mode_t m,
                                          input logic [W-1:0] ofs);
    unique case (m)
      addru_pkg::AM_POSTINC: stepOf = 16'h0001;
      addru_pkg::AM_POSTDEC, addru_pkg::AM_PREDEC: stepOf = 16'hFFFF;
      addru_pkg::AM_POSTOFS: stepOf = ofs;
      default: stepOf = 16'h0000;
    endcase
  endfunction : stepOf

  function automatic logic updates(input addru_pkg::addru_mode_t m);
    updates = (m == addru_pkg::AM_POSTINC) || (m == addru_pkg::AM_POSTDEC)
              || (m == addru_pkg::AM_POSTOFS) || (m == addru_pkg::AM_PREDEC);
  endfunction : updates

  // ==========================================
  // Issue control: extra cycle for second word, blocking of parallel moves
  wire logic inExtra = (state == addru_pkg::ST_EXTRA);
  wire logic issue = instValid && !inExtra;
  wire logic parallelOk = issue && !instBlocksParallel;
  wire logic doFirst = parallelOk && firstEnable;
  wire logic doSecond = parallelOk && secondEnable;
  wire logic firstIsPtr = (firstSource == addru_pkg::SRC_POINTER);

  always_comb begin
    next_state = state;
    unique case (state)
      addru_pkg::ST_EXEC: if (issue && instTwoWord) next_state = addru_pkg::ST_EXTRA;
      addru_pkg::ST_EXTRA: next_state = addru_pkg::ST_EXEC;
    endcase
  end

  // ==========================================
  // First access: paired files by the same index
  wire logic [W-1:0] fPtr = pointerFile[firstIndex];
  wire logic [W-1:0] fOfs = offsetFile[firstIndex];
  wire logic [W-1:0] fMod = modifierFile[firstIndex];
  wire logic [W-1:0] dispExt = {{(W-7){shortDisp[6]}}, shortDisp};
  wire logic [W-1:0] fStep = stepOf(firstMode, fOfs);
  logic [W-1:0] fUpdated;
  logic [W-1:0] fIndexed;
  logic [W-1:0] fDisp;
  addru_update #(.W(W)) u_first (
    .pointer(fPtr), .step(fStep), .modifier(fMod), .noModulo(1'b0), .result(fUpdated)
  );
  // Offset-indexed form also uses the modifier arithmetic; short displacement stays linear
  addru_update #(.W(W)) u_index (
    .pointer(fPtr), .step(fOfs), .modifier(fMod), .noModulo(1'b0), .result(fIndexed)
  );
  addru_update #(.W(W)) u_disp (
    .pointer(fPtr), .step(dispExt), .modifier(fMod), .noModulo(1'b1), .result(fDisp)
  );
  // Effective location selection
  wire logic [W-1:0] fPtrEa = (firstMode == addru_pkg::AM_INDEXED) ? fIndexed :
                              (firstMode == addru_pkg::AM_SHORTDISP) ? fDisp :
                              (firstMode == addru_pkg::AM_PREDEC) ? fUpdated : fPtr;
  wire logic [W-1:0] fEa = firstIsPtr ? fPtrEa :
                           (firstSource == addru_pkg::SRC_ACCUPPER) ? accUpper : immediateAddr;
  wire logic fWrite = doFirst && firstIsPtr && updates(firstMode);

  // ==========================================
  // Second access: always pointer 3, plain linear update
  wire logic [W-1:0] sPtr = pointerFile[addru_pkg::DUAL_PTR];
  wire logic [W-1:0] sStep = stepOf(secondMode, offsetFile[addru_pkg::DUAL_PTR]);
  logic [W-1:0] sUpdated;
  addru_update #(.W(W)) u_second (
    .pointer(sPtr), .step(sStep), .modifier(addru_pkg::MOD_LINEAR), .noModulo(1'b1),
    .result(sUpdated)
  );
  wire logic [W-1:0] sEa = (secondMode == addru_pkg::AM_PREDEC) ? sUpdated : sPtr;
  wire logic sWrite = doSecond && updates(secondMode);

  // ==========================================
  // State and registered outputs; both addresses land in one cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= addru_pkg::ST_EXEC;
      firstAddr <= '0;
      firstValid <= 1'b0;
      secondAddr <= '0;
      secondValid <= 1'b0;
      busy <= 1'b0;
      pointerView <= '0;
    end else begin
      state <= next_state;
      firstAddr <= doFirst ? fEa : firstAddr;
      firstValid <= doFirst;
      secondAddr <= doSecond ? sEa : secondAddr;
      secondValid <= doSecond;
      busy <= (next_state == addru_pkg::ST_EXTRA);
      pointerView <= pointerFile[firstIndex];
    end
  end

  // Register file writes; one modulo update per cycle, pointer 3 gets linear path
  for (genvar g = 0; g < addru_pkg::NUM_PTR; g++) begin : g_files
    wire logic fHit = fWrite && (firstIndex == 2'(g));
    wire logic sHit = sWrite && (2'(g) == addru_pkg::DUAL_PTR) && !fHit;
    wire logic wHit = writeEnable && (writeIndex == 2'(g));
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        pointerFile[g] <= addru_pkg::RESET_PTR;
        offsetFile[g] <= addru_pkg::RESET_OFS;
        modifierFile[g] <= addru_pkg::RESET_MOD;
      end else begin
        if (fHit) pointerFile[g] <= fUpdated;
        else if (sHit) pointerFile[g] <= sUpdated;
        else if (wHit && writeFile == 2'h0) pointerFile[g] <= writeData;
        if (wHit && writeFile == 2'h1) offsetFile[g] <= writeData;
        if (wHit && writeFile == 2'h2) modifierFile[g] <= writeData;
      end
    end
  end

  // ==========================================
  // Checks
  wire logic fHitAny = fWrite && (firstIndex == addru_pkg::DUAL_PTR);
  sequence s_twoWordIssue;
    issue && instTwoWord;
  endsequence
  // Busy for exactly the one extra cycle, so the next word is never lost
  sequence s_oneBusyCycle;
    busy ##1 !busy;
  endsequence
  chk_extra_cycle: assert property (@(posedge ref_clk) disable iff (reset)
    s_twoWordIssue |=> s_oneBusyCycle) else $error("no extra cycle");
  chk_extra_ignored: assert property (@(posedge ref_clk) disable iff (reset)
    inExtra |=> !firstValid && !secondValid) else $error("request taken in extra cycle");
  chk_busy_single: assert property (@(posedge ref_clk) disable iff (reset)
    busy |=> !busy) else $error("busy held past one cycle");
  chk_block_parallel: assert property (@(posedge ref_clk) disable iff (reset)
    (instValid && instBlocksParallel) |=> !firstValid && !secondValid)
    else $error("parallel move not blocked");
  // Own port writes are left out, they may legally move a pointer then
  chk_blocked_hold: assert property (@(posedge ref_clk) disable iff (reset)
    (instValid && instBlocksParallel && !writeEnable) |=>
    (pointerFile[$past(firstIndex)] == $past(fPtr)) && (pointerFile[3] == $past(sPtr)))
    else $error("blocked instruction moved a pointer");
  chk_second_linear: assert property (@(posedge ref_clk) disable iff (reset)
    (sWrite && !fHitAny) |=> pointerFile[3] == $past(sPtr) + $past(sStep))
    else $error("second update not linear");
  chk_plain_ea: assert property (@(posedge ref_clk) disable iff (reset)
    (doFirst && firstIsPtr && firstMode == addru_pkg::AM_POSTINC) |=> firstAddr == $past(fPtr))
    else $error("pointer not used as address");
  chk_short_disp: assert property (@(posedge ref_clk) disable iff (reset)
    (doFirst && firstIsPtr && firstMode == addru_pkg::AM_SHORTDISP) |=>
    firstAddr == $past(fPtr) + $past(dispExt)) else $error("displacement address wrong");
  // Linear indexed address must add the offset of the same index
  chk_indexed_pair: assert property (@(posedge ref_clk) disable iff (reset)
    (doFirst && firstIsPtr && firstMode == addru_pkg::AM_INDEXED
     && fMod == addru_pkg::MOD_LINEAR) |=> firstAddr == $past(fPtr) + $past(fOfs))
    else $error("indexed address not paired");
  chk_acc_addr: assert property (@(posedge ref_clk) disable iff (reset)
    (doFirst && firstSource == addru_pkg::SRC_ACCUPPER) |=> firstAddr == $past(accUpper))
    else $error("accumulator address wrong");
  // Modulo and reverse carry results are left to the bench rows
  chk_linear_wrap: assert property (@(posedge ref_clk) disable iff (reset)
    (fWrite && fMod == addru_pkg::MOD_LINEAR) |=>
    pointerFile[$past(firstIndex)] == $past(fPtr) + $past(fStep))
    else $error("linear update wrong");
  chk_dual_same: assert property (@(posedge ref_clk) disable iff (reset)
    (doFirst && doSecond) |=> firstValid && secondValid)
    else $error("dual access not in one cycle");
  chk_second_ea: assert property (@(posedge ref_clk) disable iff (reset)
    (doSecond && secondMode == addru_pkg::AM_POSTINC) |=> secondAddr == $past(sPtr))
    else $error("second address wrong");
endmodule : address_unit

// ### tb/addru_mem_model.sv
// Data memory bus model that logs the reads the unit presents
`timescale 1ns/1ps
module addru_mem_model (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic firstValid,
  input wire logic [15:0] firstAddr,
  input wire logic secondValid,
  input wire logic [15:0] secondAddr,
  output logic [15:0] accessCount,
  output logic [15:0] lastSecond
);
  // ==========================================
  // Access log: both reads of one cycle count, so a lost pulse shows
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      accessCount <= 16'h0000;
      lastSecond <= 16'h0000;
    end else begin
      accessCount <= accessCount + 16'(firstValid) + 16'(secondValid);
      if (secondValid) begin
        lastSecond <= secondAddr;
      end
    end
  end
endmodule : addru_mem_model

// ### tb/tb_address_unit.sv
// Self-checking bench of the address unit
`timescale 1ns/1ps
module tb_address_unit;
  // Mode and source kept as raw codes so the table stays narrow
  typedef struct packed {
    logic [2:0] src;
    logic [1:0] idx;
    logic [2:0] mode;
    logic [15:0] ptr, ofs, mdf, expA, expP;
  } addru_row_t;
  logic ref_clk, reset, instValid, instTwoWord, instBlocksParallel, firstEnable;
  logic secondEnable, writeEnable, firstValid, secondValid, busy;
  logic [1:0] firstIndex, writeFile, writeIndex;
  logic [6:0] shortDisp;
  logic [15:0] accUpper, immediateAddr, writeData, firstAddr, secondAddr, pointerView;
  logic [15:0] accessCount, lastSecond;
  addru_pkg::addru_mode_t firstMode, secondMode;
  addru_pkg::addru_src_t firstSource;
  int nFail = 0;
  int nTests = 0;
  // ==========================================
  // Cases: src, index, mode, pointer, offset, modifier, address, new pointer
  addru_row_t rows[15] = '{
    '{3'h0, 2'h0, 3'h1, 16'hFFFF, 16'h0000, 16'hFFFF, 16'hFFFF, 16'h0000},
    '{3'h0, 2'h1, 3'h2, 16'h0000, 16'h0000, 16'hFFFF, 16'h0000, 16'hFFFF},
    '{3'h0, 2'h2, 3'h3, 16'h0010, 16'hFFFE, 16'hFFFF, 16'h0010, 16'h000E},
    '{3'h0, 2'h3, 3'h4, 16'h0100, 16'h0020, 16'hFFFF, 16'h0120, 16'h0100},
    '{3'h0, 2'h0, 3'h5, 16'h0005, 16'h0000, 16'hFFFF, 16'h0004, 16'h0004},
    '{3'h0, 2'h1, 3'h3, 16'h0000, 16'h0200, 16'h0000, 16'h0000, 16'h0200},
    '{3'h0, 2'h1, 3'h3, 16'h0200, 16'h0200, 16'h0000, 16'h0200, 16'h0100},
    '{3'h0, 2'h1, 3'h3, 16'h0100, 16'h0200, 16'h0000, 16'h0100, 16'h0300},
    '{3'h0, 2'h2, 3'h2, 16'h0010, 16'h0000, 16'h0003, 16'h0010, 16'h0013},
    '{3'h0, 2'h3, 3'h0, 16'h0ABC, 16'h0000, 16'hFFFF, 16'h0ABC, 16'h0ABC},
    '{3'h0, 2'h2, 3'h6, 16'h0100, 16'h0000, 16'hFFFF, 16'h00FE, 16'h0100},
    '{3'h1, 2'h0, 3'h0, 16'h0005, 16'h0000, 16'hFFFF, 16'h1234, 16'h0005},
    '{3'h3, 2'h0, 3'h0, 16'h0007, 16'h0000, 16'hFFFF, 16'h5678, 16'h0007},
    '{3'h2, 2'h1, 3'h0, 16'h0009, 16'h0000, 16'hFFFF, 16'h5678, 16'h0009},
    '{3'h4, 2'h2, 3'h0, 16'h000A, 16'h0000, 16'hFFFF, 16'h5678, 16'h000A}};

  address_unit dut_u (.ref_clk, .reset, .instValid, .instTwoWord, .instBlocksParallel,
    .firstEnable, .firstIndex, .firstMode, .firstSource, .shortDisp, .accUpper,
    .immediateAddr, .secondEnable, .secondMode, .writeEnable, .writeFile, .writeIndex,
    .writeData, .firstAddr, .firstValid, .secondAddr, .secondValid, .busy, .pointerView);
  addru_mem_model mem_u (.ref_clk, .reset, .firstValid, .firstAddr, .secondValid,
    .secondAddr, .accessCount, .lastSecond);

  // ==========================================
  // Clock, watchdog and shared tasks
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    nFail++;
    giveVerdict();
  end
  task automatic cyc;
    @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    nTests++;
    if (seen !== exp) begin
      nFail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Write strobe stays up between writes; the next access drops it
  task automatic wr(input logic [1:0] f, input logic [1:0] i, input logic [15:0] d);
    writeEnable = 1'b1;
    writeFile = f;
    writeIndex = i;
    writeData = d;
    cyc();
  endtask : wr
  task automatic go(input addru_row_t r, input logic en2);
    firstSource = addru_pkg::addru_src_t'(r.src);
    firstMode = addru_pkg::addru_mode_t'(r.mode);
    firstIndex = r.idx;
    firstEnable = 1'b1;
    secondEnable = en2;
    writeEnable = 1'b0;
    instValid = 1'b1;
    cyc();
    instValid = 1'b0;
    chk("firstValid", {15'h0000, firstValid}, 16'h0001);
    chk("secondValid", {15'h0000, secondValid}, {15'h0000, en2});
    chk("firstAddr", firstAddr, r.expA);
    cyc();
    chk("pointerView", pointerView, r.expP);
  endtask : go
  task automatic giveVerdict;
    $display("Checks %0d, errors %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : giveVerdict

  // ==========================================
  // Main sequence; reverse rows use offset 512 from base 0
  initial begin
    {instValid, instTwoWord, instBlocksParallel, firstEnable, secondEnable} = '0;
    {writeEnable, writeFile, writeIndex, writeData, firstIndex} = '0;
    firstMode = addru_pkg::AM_NONE;
    secondMode = addru_pkg::AM_POSTINC;
    firstSource = addru_pkg::SRC_POINTER;
    shortDisp = 7'h7E;
    accUpper = 16'h1234;
    immediateAddr = 16'h5678;
    reset = 1'b1;
    repeat (6) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    chk("busy", {15'h0000, busy}, 16'h0000);
    chk("firstAddr", firstAddr, 16'h0000);
    foreach (rows[k]) begin
      wr(2'h0, rows[k].idx, rows[k].ptr);
      wr(2'h1, rows[k].idx, rows[k].ofs);
      wr(2'h2, rows[k].idx, rows[k].mdf);
      go(rows[k], 1'b0);
    end
    // Dual read: pointer 3 must step linearly past its modulo bound
    wr(2'h0, 2'h3, 16'h0013);
    wr(2'h2, 2'h3, 16'h0003);
    wr(2'h0, 2'h0, 16'h0040);
    go(addru_row_t'{3'h0, 2'h0, 3'h1, 16'h0, 16'h0, 16'h0, 16'h0040, 16'h0041}, 1'b1);
    chk("secondAddr", lastSecond, 16'h0013);
    firstIndex = 2'h3;
    cyc();
    cyc();
    chk("pointer3", pointerView, 16'h0014);
    // Blocked instruction: no access and no pointer step
    instBlocksParallel = 1'b1;
    instValid = 1'b1;
    cyc();
    instValid = 1'b0;
    chk("firstValid", {15'h0000, firstValid}, 16'h0000);
    instBlocksParallel = 1'b0;
    cyc();
    chk("pointer3", pointerView, 16'h0014);
    // Two-word instruction: request held into the extra cycle is ignored
    instTwoWord = 1'b1;
    instValid = 1'b1;
    cyc();
    instTwoWord = 1'b0;
    chk("busy", {15'h0000, busy}, 16'h0001);
    chk("firstAddr", firstAddr, 16'h0014);
    cyc();
    instValid = 1'b0;
    chk("firstValid", {15'h0000, firstValid}, 16'h0000);
    cyc();
    chk("pointer3", pointerView, 16'h0015);
    chk("accessCount", accessCount, 16'h0013);
    // Reset in mid-run: pointers clear and modifiers fall back to linear
    reset = 1'b1;
    cyc();
    reset = 1'b0;
    chk("busy", {15'h0000, busy}, 16'h0000);
    go(addru_row_t'{3'h0, 2'h3, 3'h2, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hFFFF}, 1'b0);
    giveVerdict();
  end
endmodule : tb_address_unit
